/* File: rtl/dscv_pkg.sv */
// shared constants and carrier types for the dac serial control and volume block
package dscv_pkg;

	localparam int FRAME_BITS = 16;
	localparam int SEL_W      = 2;
	localparam int REG_W      = 14;
	localparam int COARSE_W   = 10;
	localparam int FINE_W     = 4;
	localparam int SAMPLE_W   = 24;
	localparam int DLY_W      = 16;

	// register select codes in the low two bits of the control word
	localparam logic [1:0] SEL_LEFT  = 2'h0;
	localparam logic [1:0] SEL_CTRL  = 2'h1;
	localparam logic [1:0] SEL_RIGHT = 2'h2;

	localparam logic [13:0] VOL_RST  = 14'h3FFF;
	localparam logic [13:0] CTRL_RST = 14'h0000;

	// configuration register field positions
	localparam int CB_RATE2X   = 11;
	localparam int CB_RATE4X   = 10;
	localparam int CB_WLEN_LO  = 8;
	localparam int CB_SRST     = 7;
	localparam int CB_MUTE     = 6;
	localparam int CB_FMT_LO   = 4;
	localparam int CB_EMPH_LO  = 2;

	// de-emphasis curve selected by the emphasis pin
	localparam logic [1:0] EMPH_44K1 = 2'h1;

	// master clock periods added to the filter group delay after reset
	localparam int RESTART_EXTRA_CYC = 3;

	localparam logic [23:0] MIDSCALE = 24'h000000;

	typedef enum logic [1:0] {
		ST_HOLD = 2'h0,
		ST_WAIT = 2'h1,
		ST_RUN  = 2'h3
	} dscv_run_t;

	typedef struct packed {
		logic mute;
		logic deemph;
		logic fmt_hi;
		logic fmt_lo;
		logic rate2x;
		logic rate4x;
	} dscv_pins_t;

	typedef struct packed {
		logic       rate2x;
		logic       rate4x;
		logic [1:0] wlen;
		logic [1:0] fmt;
		logic [1:0] deemph;
		logic       mute;
	} dscv_cfg_t;

	typedef struct packed {
		logic [15:0] shreg;
	} dscv_link_t;

	typedef struct packed {
		logic                  latch_s1;
		logic                  latch_s2;
		logic                  latch_d;
		logic                  frm_s1;
		logic                  frm_s2;
		logic                  frm_d;
		logic [15:0]           word_s1;
		logic [15:0]           word_s2;
		dscv_pins_t            pin_s1;
		dscv_pins_t            pin_s2;
		logic [1:0][13:0]      vol;
		logic [13:0]           ctrl;
		dscv_cfg_t             cfg;
		dscv_run_t             run;
		logic [15:0]           dly;
		logic [1:0][9:0]       coarse;
		logic [1:0][3:0]       fine;
		logic [1:0][23:0]      out;
	} dscv_core_t;

endpackage

/* File: rtl/dscv_ctrl.sv */
// serial control port, register bank and gain ramp of the stereo dac
//
// Operation
// - every transaction is sixteen bits, most significant bit first, one whole register.
// - low two bits select the register; upper fourteen bits are stored.
// - select 00 left volume, 10 right volume, 01 configuration.
// - applied upper ten gain bits step one count per sample toward the volume.
// - lowest four volume bits skip the ramp and apply at once.
// - volume is an unsigned linear multiplier; all ones is just under unity.
// - serial input is shifted on each rising port bit clock edge while the latch is low.
// - shift register is committed to the addressed register on latch rise.
// - idle bit clocking only shifts; nothing commits without a latch.
// - new gain starts at the first frame clock edge after the latch.
// - both channels mute when mute input or configuration bit 6 is high.
// - mute entry and exit ramp the gain; unmute returns to the volume.
// - bits 3:2 pick de-emphasis curve; emphasis pin ORs in the 44.1 kHz curve code 01.
// - during reset processing stops and outputs sit at midscale.
// - output resumes group delay plus three master clocks after reset.
// - hardware reset restores registers; bit 7 resets state, keeps registers.
// - bit 11 selects 2x, bit 10 selects 4x, each ORed with its pin.
// - bits 9:8 set right-justified length: 00 24, 01 20, 10 16.
// - bits 5:4 select serial format, ORed with the two format pins.
`timescale 1ns/10ps

module dscv_ctrl #(
	parameter int FILTER_DELAY_CYC = 64
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        port_bit_clock,
	input  wire logic        port_serial_input,
	input  wire logic        latch_strobe,
	input  wire logic        frame_clock,
	input  wire logic        mute_request,
	input  wire logic        emphasis_pin,
	input  wire logic        format_pin_low,
	input  wire logic        format_pin_high,
	input  wire logic        rate2x_pin,
	input  wire logic        rate4x_pin,
	input  wire logic [23:0] sample_left,
	input  wire logic [23:0] sample_right,
	output logic      [23:0] out_left,
	output logic      [23:0] out_right,
	output logic      [13:0] gain_left,
	output logic      [13:0] gain_right,
	output logic             mute_active,
	output logic      [1:0]  deemph_sel,
	output logic      [1:0]  format_sel,
	output logic      [1:0]  word_len_sel,
	output logic             interp_2x,
	output logic             interp_4x,
	output logic             running
);

	localparam logic [15:0] DELAY_CYC =
		16'(FILTER_DELAY_CYC + dscv_pkg::RESTART_EXTRA_CYC);

	function automatic logic [9:0] dscv_step(input logic [9:0] cur, input logic [9:0] tgt);
		if (cur < tgt)
			return cur + 10'h001;
		if (cur > tgt)
			return cur - 10'h001;
		return cur;
	endfunction

	// unsigned 14-bit gain on a signed sample; full scale gain is just under unity
	function automatic logic [23:0] dscv_scale(input logic [23:0] s, input logic [13:0] g);
		logic signed [38:0] p;
		p = $signed(s) * $signed({1'b0, g});
		return p[37:14];
	endfunction

	logic [1:0] rst_sync_r;
	logic       rst_n_s;

	// reset asserts at once and releases through two core flops
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n_s = rst_sync_r[1];

	// ---------------- port bit clock domain ----------------
	dscv_pkg::dscv_link_t l_r;
	dscv_pkg::dscv_link_t l_nxt;

	// the shifter freezes while the latch is high so the word stays still for the core
	always_comb begin
		l_nxt = l_r;
		if (!latch_strobe)
			l_nxt.shreg = {l_r.shreg[14:0], port_serial_input};
	end

	// clock may stop outside frames, so reset comes straight from the pin
	always_ff @(posedge port_bit_clock or negedge rstn) begin
		if (!rstn)
			l_r <= '0;
		else
			l_r <= l_nxt;
	end

	// ---------------- core clock domain ----------------
	dscv_pkg::dscv_core_t c_r;
	dscv_pkg::dscv_core_t c_nxt;
	dscv_pkg::dscv_pins_t pins_in;
	logic [1:0][23:0]     smp;
	logic                 latch_rise;
	logic                 frame_edge;
	logic                 srst;
	logic [13:0]          ctl;

	assign pins_in = '{mute:   mute_request,
	                   deemph: emphasis_pin,
	                   fmt_hi: format_pin_high,
	                   fmt_lo: format_pin_low,
	                   rate2x: rate2x_pin,
	                   rate4x: rate4x_pin};
	assign smp        = {sample_right, sample_left};
	assign latch_rise = c_r.latch_s2 & ~c_r.latch_d;
	assign frame_edge = c_r.frm_s2 & ~c_r.frm_d;
	assign ctl        = c_r.ctrl;
	assign srst       = ctl[dscv_pkg::CB_SRST];

	always_comb begin
		c_nxt = c_r;
		c_nxt.latch_s1 = latch_strobe;
		c_nxt.latch_s2 = c_r.latch_s1;
		c_nxt.latch_d  = c_r.latch_s2;
		c_nxt.frm_s1   = frame_clock;
		c_nxt.frm_s2   = c_r.frm_s1;
		c_nxt.frm_d    = c_r.frm_s2;
		// word is only used once the synchronised latch has risen, long after it settled
		c_nxt.word_s1  = l_r.shreg;
		c_nxt.word_s2  = c_r.word_s1;
		c_nxt.pin_s1   = pins_in;
		c_nxt.pin_s2   = c_r.pin_s1;

		if (latch_rise) begin
			case (c_r.word_s2[1:0])
				dscv_pkg::SEL_LEFT: begin
					c_nxt.vol[0] = c_r.word_s2[15:2];
				end
				dscv_pkg::SEL_RIGHT: begin
					c_nxt.vol[1] = c_r.word_s2[15:2];
				end
				dscv_pkg::SEL_CTRL: begin
					c_nxt.ctrl = c_r.word_s2[15:2];
				end
				default: begin
				end
			endcase
		end

		c_nxt.cfg.rate2x = ctl[dscv_pkg::CB_RATE2X] | c_r.pin_s2.rate2x;
		c_nxt.cfg.rate4x = ctl[dscv_pkg::CB_RATE4X] | c_r.pin_s2.rate4x;
		c_nxt.cfg.wlen   = ctl[dscv_pkg::CB_WLEN_LO +: 2];
		c_nxt.cfg.fmt    = ctl[dscv_pkg::CB_FMT_LO +: 2]
		                 | {c_r.pin_s2.fmt_hi, c_r.pin_s2.fmt_lo};
		c_nxt.cfg.deemph = ctl[dscv_pkg::CB_EMPH_LO +: 2]
		                 | (c_r.pin_s2.deemph ? dscv_pkg::EMPH_44K1 : 2'h0);
		c_nxt.cfg.mute   = ctl[dscv_pkg::CB_MUTE] | c_r.pin_s2.mute;

		// soft reset parks the datapath but leaves the three registers untouched
		case (c_r.run)
			dscv_pkg::ST_HOLD: begin
				if (!srst) begin
					c_nxt.run = dscv_pkg::ST_WAIT;
					c_nxt.dly = DELAY_CYC;
				end
			end
			dscv_pkg::ST_WAIT: begin
				if (srst)
					c_nxt.run = dscv_pkg::ST_HOLD;
				else if (c_r.dly == 16'h0000)
					c_nxt.run = dscv_pkg::ST_RUN;
				else
					c_nxt.dly = c_r.dly - 16'h0001;
			end
			dscv_pkg::ST_RUN: begin
				if (srst)
					c_nxt.run = dscv_pkg::ST_HOLD;
			end
			default: begin
				c_nxt.run = dscv_pkg::ST_HOLD;
			end
		endcase

		for (int ch = 0; ch < 2; ch++) begin
			if (c_nxt.run != dscv_pkg::ST_RUN) begin
				c_nxt.coarse[ch] = 10'h000;
				c_nxt.fine[ch]   = 4'h0;
				c_nxt.out[ch]    = dscv_pkg::MIDSCALE;
			end else if (frame_edge && c_r.run == dscv_pkg::ST_RUN) begin
				// muting just retargets the same ramp to zero, so entry and exit are smooth
				c_nxt.coarse[ch] = dscv_step(c_r.coarse[ch],
					c_r.cfg.mute ? 10'h000 : c_r.vol[ch][13:4]);
				c_nxt.fine[ch]   = c_r.cfg.mute ? 4'h0 : c_r.vol[ch][3:0];
				c_nxt.out[ch]    = dscv_scale(smp[ch],
					{c_r.coarse[ch], c_r.fine[ch]});
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			c_r      <= '0;
			c_r.vol  <= {dscv_pkg::VOL_RST, dscv_pkg::VOL_RST};
			c_r.ctrl <= dscv_pkg::CTRL_RST;
			c_r.run  <= dscv_pkg::ST_HOLD;
			c_r.out  <= {dscv_pkg::MIDSCALE, dscv_pkg::MIDSCALE};
		end else begin
			c_r <= c_nxt;
		end
	end

	assign out_left     = c_r.out[0];
	assign out_right    = c_r.out[1];
	assign gain_left    = {c_r.coarse[0], c_r.fine[0]};
	assign gain_right   = {c_r.coarse[1], c_r.fine[1]};
	assign mute_active  = c_r.cfg.mute;
	assign deemph_sel   = c_r.cfg.deemph;
	assign format_sel   = c_r.cfg.fmt;
	assign word_len_sel = c_r.cfg.wlen;
	assign interp_2x    = c_r.cfg.rate2x;
	assign interp_4x    = c_r.cfg.rate4x;
	assign running      = (c_r.run == dscv_pkg::ST_RUN);

	// ---------------- checks ----------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n_s);

	chk_write_left: assert property (
		latch_rise && c_r.word_s2[1:0] == 2'h0 |=> c_r.vol[0] == $past(c_r.word_s2[15:2]))
		else $error("left volume not written from control word");

	chk_write_right: assert property (
		latch_rise && c_r.word_s2[1:0] == 2'h2 |=> c_r.vol[1] == $past(c_r.word_s2[15:2])
			&& $stable(c_r.vol[0]) && $stable(c_r.ctrl))
		else $error("right volume write wrong or disturbed other registers");

	chk_write_ctrl: assert property (
		latch_rise && c_r.word_s2[1:0] == 2'h1 |=> c_r.ctrl == $past(c_r.word_s2[15:2])
			&& $stable(c_r.vol))
		else $error("configuration write wrong");

	chk_no_commit: assert property (
		!latch_rise |=> $stable(c_r.vol) && $stable(c_r.ctrl))
		else $error("register changed without latch");

	chk_ramp_step: assert property (
		running && !srst |=> c_r.coarse[0] == $past(c_r.coarse[0])
			|| c_r.coarse[0] == $past(c_r.coarse[0]) + 10'h001
			|| c_r.coarse[0] == $past(c_r.coarse[0]) - 10'h001)
		else $error("left gain moved more than one count");

	chk_ramp_hold: assert property (
		running && !srst && !frame_edge |=> $stable(c_r.coarse) && $stable(c_r.out))
		else $error("gain changed between frame edges");

	chk_fine_direct: assert property (
		running && !srst && frame_edge && !c_r.cfg.mute |=> c_r.fine[1] == $past(c_r.vol[1][3:0]))
		else $error("fine gain bits not applied at once");

	chk_mute_ramp: assert property (
		running && !srst && frame_edge && c_r.cfg.mute && c_r.coarse[0] != 10'h000
		|=> c_r.coarse[0] == $past(c_r.coarse[0]) - 10'h001 && c_r.fine[0] == 4'h0)
		else $error("mute did not ramp gain down");

	chk_mute_or: assert property (
		1'b1 |=> c_r.cfg.mute == ($past(c_r.pin_s2.mute) | $past(ctl[6])))
		else $error("mute is not the OR of pin and bit");

	chk_deemph_sel: assert property (
		$past(c_r.pin_s2.deemph) && $past(ctl[3:2]) == 2'h0 |-> deemph_sel == 2'h1)
		else $error("emphasis pin did not select 44.1 kHz curve");

	chk_rate_or: assert property (
		1'b1 |=> interp_2x == ($past(ctl[11]) | $past(c_r.pin_s2.rate2x))
			&& interp_4x == ($past(ctl[10]) | $past(c_r.pin_s2.rate4x))
			&& word_len_sel == $past(ctl[9:8])
			&& format_sel == ($past(ctl[5:4]) | $past({c_r.pin_s2.fmt_hi, c_r.pin_s2.fmt_lo})))
		else $error("configuration outputs do not follow register and pins");

	chk_midscale: assert property (
		!running |-> out_left == 24'h000000 && out_right == 24'h000000 && gain_left == 14'h0000)
		else $error("outputs not at midscale while halted");

	chk_restart_wait: assert property (
		c_r.run == dscv_pkg::ST_HOLD && !srst |=> c_r.dly == DELAY_CYC
			&& c_r.run == dscv_pkg::ST_WAIT)
		else $error("restart delay not loaded");

	chk_restart_run: assert property (
		$rose(running) |-> $past(c_r.dly) == 16'h0000 && $past(c_r.run) == dscv_pkg::ST_WAIT)
		else $error("running before restart delay expired");

	cov_write_left: cover property (latch_rise && c_r.word_s2[1:0] == 2'h0);
	cov_mute_ramp:  cover property (running && frame_edge && c_r.cfg.mute
		&& c_r.coarse[0] != 10'h000);
	cov_soft_reset: cover property (running ##1 !running);
	cov_ramp_up:    cover property (running && frame_edge && c_r.coarse[1] < c_r.vol[1][13:4]);

endmodule

/* File: test/dscv_host.sv */
// host model driving the three-wire serial control port
`timescale 1ns/10ps

module dscv_host (
	output logic port_bit_clock,
	output logic port_serial_input,
	output logic latch_strobe
);
	initial begin
		port_bit_clock = 1'b0;
		port_serial_input = 1'b0;
		latch_strobe = 1'b0;
	end

	// bit clock stands still outside frames; a frame without commit models idle clocking
	task automatic send(input logic [15:0] w, input logic commit);
		for (int i = 15; i >= 0; i--) begin
			port_serial_input = w[i];
			#3 port_bit_clock = 1'b1;
			#3 port_bit_clock = 1'b0;
		end
		latch_strobe = commit;
		port_serial_input = ~w[0];
		// latch held past four core clocks so the two-flop copy of the shifter settles
		#250 latch_strobe = 1'b0;
		#150;
	endtask
endmodule

/* File: test/dscv_ctrl_tb.sv */
// self-checking bench for the serial control, register bank and gain ramp
`timescale 1ns/10ps

module dscv_ctrl_tb;
	localparam int DLY = 2;
	logic        core_clk;
	logic        rstn;
	logic        frame_clock;
	logic        mute_request;
	logic        emphasis_pin;
	logic        format_pin_low;
	logic        format_pin_high;
	logic        rate2x_pin;
	logic        rate4x_pin;
	logic [23:0] sample_left;
	logic [23:0] sample_right;
	wire         port_bit_clock;
	wire         port_serial_input;
	wire         latch_strobe;
	logic [23:0] out_left;
	logic [23:0] out_right;
	logic [13:0] gain_left;
	logic [13:0] gain_right;
	logic        mute_active;
	logic [1:0]  deemph_sel;
	logic [1:0]  format_sel;
	logic [1:0]  word_len_sel;
	logic        interp_2x;
	logic        interp_4x;
	logic        running;
	int          err_total;
	int          checks_done;

	dscv_host u_host (.port_bit_clock, .port_serial_input, .latch_strobe);

	dscv_ctrl #(.FILTER_DELAY_CYC(DLY)) u_dut (
		.core_clk, .rstn, .port_bit_clock, .port_serial_input, .latch_strobe,
		.frame_clock, .mute_request, .emphasis_pin, .format_pin_low, .format_pin_high,
		.rate2x_pin, .rate4x_pin, .sample_left, .sample_right, .out_left, .out_right,
		.gain_left, .gain_right, .mute_active, .deemph_sel, .format_sel, .word_len_sel,
		.interp_2x, .interp_4x, .running
	);

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic wr(input logic [15:0] w, input logic commit);
		u_host.send(w, commit);
		cyc(2);
	endtask

	task automatic frame(input int n);
		repeat (n) begin
			frame_clock = 1'b1;
			cyc(3);
			frame_clock = 1'b0;
			cyc(3);
		end
	endtask

	task automatic wait_run();
		int n;
		n = 0;
		while (running !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		check(24'(running), 24'h1);
	endtask

	task automatic hw_reset(input int n);
		rstn = 1'b0;
		cyc(n);
		check(24'({running, gain_left}), 24'h0);
		check(out_left, 24'h0);
		check(24'({deemph_sel, format_sel, word_len_sel, interp_2x, interp_4x}), 24'h0);
		rstn = 1'b1;
		cyc(DLY + 1);
		check(24'(running), 24'h0);
		wait_run();
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		err_total++;
		tally_and_finish();
	end

	initial begin
		logic [13:0] c;
		err_total = 0;
		checks_done = 0;
		rstn = 1'b0;
		frame_clock = 1'b0;
		mute_request = 1'b0;
		{emphasis_pin, format_pin_high, format_pin_low, rate2x_pin, rate4x_pin} = 5'h00;
		sample_left = 24'h400000;
		sample_right = 24'h400000;
		hw_reset(4);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			c = 14'((k << 8) | (k << 4) | (k << 2) | ((k >> 1) << 11) | ((k & 1) << 10));
			wr({c, dscv_pkg::SEL_CTRL}, 1'b1);
			check(24'({deemph_sel, format_sel, word_len_sel}), 24'({3{k[1:0]}}));
			check(24'({interp_2x, interp_4x}), 24'(k[1:0]));
		end
		$display("test config fields done");
		wr({14'h0000, dscv_pkg::SEL_CTRL}, 1'b1);
		// mute first so the format change cannot click
		mute_request = 1'b1;
		cyc(3);
		{emphasis_pin, format_pin_high, format_pin_low, rate2x_pin, rate4x_pin} = 5'h1F;
		cyc(5);
		check(24'({deemph_sel, format_sel, interp_2x, interp_4x}), 24'h1F);
		{emphasis_pin, format_pin_high, format_pin_low, rate2x_pin, rate4x_pin} = 5'h00;
		cyc(5);
		check(24'({deemph_sel, format_sel, interp_2x, interp_4x}), 24'h00);
		mute_request = 1'b0;
		cyc(3);
		$display("test pins done");
		wr({14'h0010, dscv_pkg::SEL_CTRL}, 1'b0);
		wr({14'h0010, 2'h3}, 1'b1);
		check(24'(format_sel), 24'h0);
		$display("test ignored words done");
		wr({14'h0035, dscv_pkg::SEL_LEFT}, 1'b1);
		wr({14'h0028, dscv_pkg::SEL_RIGHT}, 1'b1);
		check(24'(gain_left), 24'h0);
		for (int i = 0; i < 4; i++) begin
			frame(1);
			check(24'(gain_left), 24'(((i < 3 ? i + 1 : 3) << 4) | 5));
			check(24'(gain_right), 24'(((i < 2 ? i + 1 : 2) << 4) | 8));
		end
		check(out_left, 24'h003500);
		check(out_right, 24'h002800);
		wr({14'h0015, dscv_pkg::SEL_LEFT}, 1'b1);
		frame(1);
		check(24'(gain_left), 24'h25);
		$display("test volume ramp done");
		// the pin needs three core edges to reach the ramp, so let it settle before the frame
		mute_request = 1'b1;
		cyc(3);
		frame(1);
		check(24'(mute_active), 24'h1);
		check(24'(gain_left), 24'h10);
		mute_request = 1'b0;
		cyc(3);
		frame(1);
		check(24'(gain_left), 24'h15);
		wr({14'h0040, dscv_pkg::SEL_CTRL}, 1'b1);
		check(24'(mute_active), 24'h1);
		frame(1);
		check(24'(gain_left), 24'h00);
		wr({14'h0000, dscv_pkg::SEL_CTRL}, 1'b1);
		check(24'(mute_active), 24'h0);
		$display("test mute done");
		wr({14'h00A0, dscv_pkg::SEL_CTRL}, 1'b1);
		cyc(2);
		check(24'({running, gain_left}), 24'h0);
		check(24'(format_sel), 24'h2);
		wr({14'h0000, dscv_pkg::SEL_CTRL}, 1'b1);
		wait_run();
		frame(1);
		check(24'(gain_left), 24'h15);
		$display("test soft reset done");
		hw_reset(64);
		frame(1);
		check(24'(gain_left), 24'h1F);
		$display("test hardware reset done");
		tally_and_finish();
	end
endmodule
